// ---- verilog/port_io_latch_match.sv ----
// Port latches, pin readback, port match event and crossbar route config
// What this block does
// - Pins the crossbar does not claim act as plain I/O through the port register.
// - Port registers accept both whole byte and single bit accesses.
// - A write stores into an output latch that holds the pin data until the next write.
// - A plain read returns the pin levels whatever the crossbar routing.
// - Read-modify-write instructions operate on the latch, not on the pins.
// - Single bit move, clear and set modify one latch bit and keep the others.
// - A match event fires when masked pins of port zero or port one differ from compare.
// - Match uses pin levels irrespective of crossbar routing.
// - The match event requests an interrupt only while its enable bit is one.
// - The match event can wake the suspended internal oscillator.
// - Latch zero drives low, one drives high or floats for open-drain pins.
// - The crossbar enable bit turns routing on; when clear pins are plain inputs.
// - Output drivers stay off while the crossbar is disabled.
// - Weak pull-ups act on open-drain pins not driving low unless disabled.
`timescale 1ns/10ps
module port_io_latch_match
    import port_io_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Register access from the core
    input  wire sfr_req_t   req_i,
    output logic [7:0]      rdata_o,
    // Pins of ports zero and one
    input  wire logic [7:0] p0_in_i,
    input  wire logic [7:0] p1_in_i,
    output logic [7:0]      p0_out_o,
    output logic [7:0]      p0_oe_o,
    output logic [7:0]      p1_out_o,
    output logic [7:0]      p1_oe_o,
    output logic [7:0]      p0_pullup_o,
    output logic [7:0]      p1_pullup_o,
    // Analog mode of each pin, kept by another block
    input  wire logic [7:0] p0_analog_i,
    input  wire logic [7:0] p1_analog_i,
    // Events and routing
    output logic            match_irq_o,
    output logic            osc_wake_o,
    output route_t          route_o,
    output logic            crossbar_enable_o
);

    logic [7:0] port_zero_latch;
    logic [7:0] port_one_latch;
    logic [7:0] crossbar_route_config;
    logic [7:0] port_zero_compare_mask;
    logic [7:0] port_zero_compare_value;
    logic [7:0] port_one_compare_mask;
    logic [7:0] port_one_compare_value;
    logic [7:0] port_zero_output_mode;
    logic [7:0] port_one_output_mode;
    logic       match_interrupt_enable;
    logic [7:0] next_p0;
    logic [7:0] next_p1;
    logic       match_now;
    logic       crossbar_enable;
    logic       weak_pullup_disable;
    logic [2:0] counter_array_module_pin_select;

    assign crossbar_enable = crossbar_route_config[XBAR_BIT];
    assign weak_pullup_disable = crossbar_route_config[WPUD_BIT];
    assign counter_array_module_pin_select = crossbar_route_config[MSEL_HI:0];

    // New latch value for a port access
    function automatic logic [7:0] latch_update(
        input sfr_req_t   r,
        input logic [7:0] latch,
        input logic [7:0] pins
    );
        logic [7:0] v;
        v = latch;
        if (r.bit_op)
        begin
            v[r.bit_sel] = r.bit_val;
        end
        else
        begin
            v = r.wdata;
        end
        return v;
    endfunction

    always_comb
    begin
        next_p0 = latch_update(req_i, port_zero_latch, p0_in_i);
        next_p1 = latch_update(req_i, port_one_latch, p1_in_i);
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            port_zero_latch <= RST_LATCH;
        else if (req_i.wr && req_i.addr == ADDR_PORT_ZERO)
            port_zero_latch <= next_p0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            port_one_latch <= RST_LATCH;
        else if (req_i.wr && req_i.addr == ADDR_PORT_ONE)
            port_one_latch <= next_p1;
    end

    // Configuration registers, byte writes only
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            crossbar_route_config   <= RST_ROUTE_CFG;
            port_zero_compare_mask  <= RST_ZERO;
            port_zero_compare_value <= RST_ZERO;
            port_one_compare_mask   <= RST_ZERO;
            port_one_compare_value  <= RST_ZERO;
            port_zero_output_mode   <= RST_ZERO;
            port_one_output_mode    <= RST_ZERO;
            match_interrupt_enable  <= 1'b0;
        end
        else if (req_i.wr && !req_i.bit_op)
        begin
            unique case (req_i.addr)
                ADDR_ROUTE_CFG: crossbar_route_config   <= req_i.wdata;
                ADDR_P0_MASK:   port_zero_compare_mask  <= req_i.wdata;
                ADDR_P0_VALUE:  port_zero_compare_value <= req_i.wdata;
                ADDR_P1_MASK:   port_one_compare_mask   <= req_i.wdata;
                ADDR_P1_VALUE:  port_one_compare_value  <= req_i.wdata;
                ADDR_P0_OMODE:  port_zero_output_mode   <= req_i.wdata;
                ADDR_P1_OMODE:  port_one_output_mode    <= req_i.wdata;
                ADDR_EXT_IE2:   match_interrupt_enable  <= req_i.wdata[MATCH_INTERRUPT_ENABLE_BIT];
                default:        ;
            endcase
        end
    end

    // Read data; RMW reads see the latch so the core modifies latch contents
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_o <= RST_ZERO;
        else if (req_i.rd)
        begin
            unique case (req_i.addr)
                ADDR_PORT_ZERO: rdata_o <= req_i.rmw ? port_zero_latch : p0_in_i;
                ADDR_PORT_ONE:  rdata_o <= req_i.rmw ? port_one_latch : p1_in_i;
                ADDR_ROUTE_CFG: rdata_o <= crossbar_route_config;
                ADDR_P0_MASK:   rdata_o <= port_zero_compare_mask;
                ADDR_P0_VALUE:  rdata_o <= port_zero_compare_value;
                ADDR_P1_MASK:   rdata_o <= port_one_compare_mask;
                ADDR_P1_VALUE:  rdata_o <= port_one_compare_value;
                ADDR_P0_OMODE:  rdata_o <= port_zero_output_mode;
                ADDR_P1_OMODE:  rdata_o <= port_one_output_mode;
                ADDR_EXT_IE2:   rdata_o <= {6'h00, match_interrupt_enable, 1'b0};
                default:        rdata_o <= RST_ZERO;
            endcase
        end
    end

    assign match_now =
        ((p0_in_i & port_zero_compare_mask) != (port_zero_compare_value & port_zero_compare_mask))
     || ((p1_in_i & port_one_compare_mask) != (port_one_compare_value & port_one_compare_mask));

    // Event outputs registered, one cycle behind the pins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            match_irq_o <= 1'b0;
            osc_wake_o  <= 1'b0;
        end
        else
        begin
            match_irq_o <= match_now && match_interrupt_enable;
            osc_wake_o  <= match_now;
        end
    end

    // Pin drivers per bit; analog pins never drive or pull
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        always_ff @(posedge mclk_i)
        begin
            if (rst_i)
            begin
                p0_out_o[i]    <= 1'b0;
                p0_oe_o[i]     <= 1'b0;
                p1_out_o[i]    <= 1'b0;
                p1_oe_o[i]     <= 1'b0;
                p0_pullup_o[i] <= 1'b0;
                p1_pullup_o[i] <= 1'b0;
            end
            else
            begin
                // low drives, high drives only push-pull
                // drivers gated by crossbar enable; plain GPIO
                p0_out_o[i] <= port_zero_latch[i];
                p0_oe_o[i]  <= crossbar_enable && !p0_analog_i[i]
                               && (!port_zero_latch[i] || port_zero_output_mode[i]);
                p1_out_o[i] <= port_one_latch[i];
                p1_oe_o[i]  <= crossbar_enable && !p1_analog_i[i]
                               && (!port_one_latch[i] || port_one_output_mode[i]);
                // weak pull-ups on open-drain pins not low
                p0_pullup_o[i] <= !weak_pullup_disable && !port_zero_output_mode[i]
                                  && !p0_analog_i[i] && !(crossbar_enable && !port_zero_latch[i]);
                p1_pullup_o[i] <= !weak_pullup_disable && !port_one_output_mode[i]
                                  && !p1_analog_i[i] && !(crossbar_enable && !port_one_latch[i]);
            end
        end
    end

    // Routing decode for the crossbar priority logic
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            route_o           <= '0;
            crossbar_enable_o <= 1'b0;
        end
        else
        begin
            crossbar_enable_o <= crossbar_enable;
            route_o.timer1 <= crossbar_enable && crossbar_route_config[T1_BIT];
            route_o.timer0 <= crossbar_enable && crossbar_route_config[T0_BIT];
            route_o.counter_array_clock_input    <= crossbar_enable && crossbar_route_config[ECI_BIT];
            // first N module outputs, code seven gives none
            if (crossbar_enable && counter_array_module_pin_select != MSEL_NONE
                && counter_array_module_pin_select <= MSEL_MAX)
                route_o.cex <= 6'(6'h3F >> (3'h6 - counter_array_module_pin_select));
            else
                route_o.cex <= 6'h00;
        end
    end

    // Checks
    AST_MATCH_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
        match_irq_o |-> $past(match_interrupt_enable))
        else $error("match interrupt without enable");
    AST_WAKE: assert property (@(posedge mclk_i) disable iff (rst_i)
        match_now |=> osc_wake_o)
        else $error("wake not raised on match");
    AST_LATCH_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !(req_i.wr && req_i.addr == ADDR_PORT_ZERO) |=> $stable(port_zero_latch))
        else $error("latch changed without write");
    AST_BIT_OP: assert property (@(posedge mclk_i) disable iff (rst_i)
        (req_i.wr && req_i.bit_op && req_i.addr == ADDR_PORT_ZERO)
        |=> port_zero_latch[$past(req_i.bit_sel)] == $past(req_i.bit_val))
        else $error("bit write lost");
    AST_RD_PIN: assert property (@(posedge mclk_i) disable iff (rst_i)
        (req_i.rd && !req_i.rmw && req_i.addr == ADDR_PORT_ONE) |=> rdata_o == $past(p1_in_i))
        else $error("read not from pins");
    AST_RD_RMW: assert property (@(posedge mclk_i) disable iff (rst_i)
        (req_i.rd && req_i.rmw && req_i.addr == ADDR_PORT_ZERO)
        |=> rdata_o == $past(port_zero_latch))
        else $error("rmw read not from latch");
    AST_OE_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
        !crossbar_enable |=> (p0_oe_o == 8'h00 && p1_oe_o == 8'h00))
        else $error("driver on with crossbar off");
    AST_PULLUP_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
        weak_pullup_disable |=> (p0_pullup_o == 8'h00 && p1_pullup_o == 8'h00))
        else $error("pullup on while disabled");
    AST_ROUTE_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
        !crossbar_enable |=> route_o == '0)
        else $error("route while crossbar off");
    COV_MATCH: cover property (@(posedge mclk_i) disable iff (rst_i) match_irq_o);
    COV_RMW: cover property (@(posedge mclk_i) disable iff (rst_i) req_i.rd && req_i.rmw);
    COV_BIT: cover property (@(posedge mclk_i) disable iff (rst_i) req_i.wr && req_i.bit_op);

endmodule

// ---- verilog/port_io_pkg.sv ----
// Package: register map, field positions and bus carrier for the port logic
package port_io_pkg;

    // Special function register addresses
    localparam logic [7:0] ADDR_PORT_ZERO  = 8'h80;
    localparam logic [7:0] ADDR_PORT_ONE   = 8'h90;
    localparam logic [7:0] ADDR_ROUTE_CFG  = 8'hE2;
    localparam logic [7:0] ADDR_P0_MASK    = 8'hC7;
    localparam logic [7:0] ADDR_P0_VALUE   = 8'hC6;
    localparam logic [7:0] ADDR_P1_MASK    = 8'hD7;
    localparam logic [7:0] ADDR_P1_VALUE   = 8'hD6;
    localparam logic [7:0] ADDR_EXT_IE2    = 8'hE7;
    localparam logic [7:0] ADDR_P0_OMODE   = 8'hA4;
    localparam logic [7:0] ADDR_P1_OMODE   = 8'hA5;

    // Reset values
    localparam logic [7:0] RST_LATCH       = 8'hFF;
    localparam logic [7:0] RST_ROUTE_CFG   = 8'h00;
    localparam logic [7:0] RST_ZERO        = 8'h00;

    // Route config field positions, then the match enable bit of ADDR_EXT_IE2
    localparam int WPUD_BIT   = 7;
    localparam int XBAR_BIT   = 6;
    localparam int T1_BIT     = 5;
    localparam int T0_BIT     = 4;
    localparam int ECI_BIT    = 3;
    localparam int MSEL_HI    = 2;
    localparam int MATCH_INTERRUPT_ENABLE_BIT   = 1;

    // Module select codes
    localparam logic [2:0] MSEL_NONE = 3'h0;
    localparam logic [2:0] MSEL_MAX  = 3'h6;

    // Access kinds from the core
    typedef enum logic [1:0] {
        ACC_BYTE_WR = 2'h0,
        ACC_BYTE_RMW = 2'h1,
        ACC_BIT_WR  = 2'h2
    } acc_kind_t;

    // One register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       rmw;
        logic       bit_op;
        logic [2:0] bit_sel;
        logic       bit_val;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Routing decode handed to the crossbar
    typedef struct packed {
        logic       timer1;
        logic       timer0;
        logic       counter_array_clock_input;
        logic [5:0] cex;
    } route_t;

endpackage

// ---- bench/pin_model.sv ----
// External pin model: resolves each pad from port drive, outside drive and pull-up
`timescale 1ns/10ps
module pin_model
(
    // Clock
    input  wire logic       mclk_i,
    // Port side of the pads
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pullup_i,
    // Outside driver, used by the bench to pull pads
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    // Resolved pad levels
    output logic [7:0]      pins_o
);
    logic [7:0] flt;

    // Floating pads change every cycle so a stale level never passes as valid
    initial flt = 8'h00;
    always_ff @(posedge mclk_i)
        flt <= ~flt;

    // Port drive wins, then outside drive, then the weak pull-up, else floating
    always_comb
        for (int i = 0; i < 8; i++)
            pins_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                        pullup_i[i] ? 1'b1 : flt[i];
endmodule

// ---- bench/port_io_latch_match_crossbar_tb.sv ----
// Self-checking bench for the port latch, match event and route config block
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch t=%0t %s", $time, msg); end end
module port_io_latch_match_crossbar_tb;
    import port_io_pkg::*;
    logic       mclk_i, rst_i;
    sfr_req_t   req;
    logic [7:0] rdata, p0_pins, p1_pins, p0_out, p0_oe, p1_out, p1_oe, p0_pu, p1_pu;
    logic [7:0] p0_an, p1_an, p0_xen, p0_xval, p1_xen, p1_xval, rd;
    logic       irq, wake, xbar;
    route_t     route;
    int         fails, cmp_count;
    logic [7:0] cfg_rows [8] = '{8'h40, 8'h61, 8'h52, 8'h4B, 8'h44, 8'h7D, 8'h46, 8'h47};
    logic [8:0] route_rows [8] = '{9'h000, 9'h101, 9'h083, 9'h047, 9'h00F, 9'h1DF,
                                   9'h03F, 9'h000};

    port_io_latch_match uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .p0_in_i(p0_pins), .p1_in_i(p1_pins), .p0_out_o(p0_out), .p0_oe_o(p0_oe),
        .p1_out_o(p1_out), .p1_oe_o(p1_oe), .p0_pullup_o(p0_pu), .p1_pullup_o(p1_pu),
        .p0_analog_i(p0_an), .p1_analog_i(p1_an), .match_irq_o(irq), .osc_wake_o(wake),
        .route_o(route), .crossbar_enable_o(xbar));
    pin_model pads0 (.mclk_i(mclk_i), .out_i(p0_out), .oe_i(p0_oe), .pullup_i(p0_pu),
        .ext_en_i(p0_xen), .ext_val_i(p0_xval), .pins_o(p0_pins));
    pin_model pads1 (.mclk_i(mclk_i), .out_i(p1_out), .oe_i(p1_oe), .pullup_i(p1_pu),
        .ext_en_i(p1_xen), .ext_val_i(p1_xval), .pins_o(p1_pins));

    // Clock at 25 MHz
    initial
    begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Bus cycles: request held over exactly one taken edge, then released
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req <= '{wr: 1'b1, addr: a, wdata: d, default: '0};
        @(posedge mclk_i);
        req <= '0;
    endtask
    task automatic bit_wr(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(posedge mclk_i);
        req <= '{wr: 1'b1, bit_op: 1'b1, bit_sel: s, bit_val: v, addr: a, default: '0};
        @(posedge mclk_i);
        req <= '0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic m, output logic [7:0] d);
        @(posedge mclk_i);
        req <= '{rd: 1'b1, rmw: m, addr: a, default: '0};
        @(posedge mclk_i);
        req <= '0;
        #1 d = rdata;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog sized well above the roughly 120 cycles the tests take
    initial
    begin
        repeat (5000) @(posedge mclk_i);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        req = '0;
        rst_i = 1'b1;
        p0_an = 8'h00;
        p1_an = 8'h00;
        {p0_xen, p0_xval, p1_xen, p1_xval} = '0;
        fails = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Reset values seen through the bus
        rd_reg(ADDR_PORT_ZERO, 1'b1, rd);
        `CHK(rd, 8'hFF, "latch reset")
        rd_reg(ADDR_ROUTE_CFG, 1'b0, rd);
        `CHK(rd, 8'h00, "route cfg reset")
        `CHK({xbar, p0_oe, irq, wake}, 11'h000, "outputs after reset")
        rd_reg(8'h01, 1'b0, rd);
        `CHK(rd, 8'h00, "unmapped read")
        $display("test done: reset");

        // Route decode for every select code, crossbar on
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(ADDR_ROUTE_CFG, cfg_rows[i]);
            idle(2);
            `CHK(route, route_t'(route_rows[i]), "route decode")
            `CHK(xbar, 1'b1, "crossbar enable")
            rd_reg(ADDR_ROUTE_CFG, 1'b0, rd);
            `CHK(rd, cfg_rows[i], "route cfg readback")
        end
        $display("test done: route table");

        // Drivers stay off until the crossbar is on
        wr_reg(ADDR_ROUTE_CFG, 8'h00);
        wr_reg(ADDR_P0_OMODE, 8'hF0);
        wr_reg(ADDR_PORT_ZERO, 8'h55);
        idle(3);
        `CHK(p0_oe, 8'h00, "drivers off without crossbar")
        wr_reg(ADDR_ROUTE_CFG, 8'h40);
        idle(3);
        `CHK(p0_out, 8'h55, "latch drives pins")
        `CHK(p0_oe, 8'hFA, "push-pull and open-drain enables")
        // Outside device pulls an open-drain high pin low
        p0_xen <= 8'h01;
        p0_xval <= 8'h00;
        idle(2);
        rd_reg(ADDR_PORT_ZERO, 1'b0, rd);
        `CHK(rd, 8'h54, "plain read returns pins")
        rd_reg(ADDR_PORT_ZERO, 1'b1, rd);
        `CHK(rd, 8'h55, "modify read returns latch")
        wr_reg(ADDR_PORT_ZERO, rd | 8'h0A);
        p0_xen <= 8'h00;
        $display("test done: latch and readback");

        // Single bit writes touch one latch bit only
        bit_wr(ADDR_PORT_ZERO, 3'h7, 1'b1);
        bit_wr(ADDR_PORT_ZERO, 3'h0, 1'b0);
        rd_reg(ADDR_PORT_ZERO, 1'b1, rd);
        `CHK(rd, 8'hDE, "bit set and clear")
        p0_an <= 8'h04;
        p1_an <= 8'h01;
        idle(3);
        `CHK(p0_pu, 8'h0A, "pull-ups on open-drain highs")
        `CHK(p1_pu, 8'hFE, "port one pull-ups, analog pin off")
        `CHK(p1_out, 8'hFF, "port one latch drives pins")
        `CHK(p1_oe, 8'h00, "open-drain highs float")
        wr_reg(ADDR_ROUTE_CFG, 8'hC0);
        idle(3);
        `CHK({p0_pu, p1_pu}, 16'h0000, "pull-ups disabled")
        $display("test done: bits and pull-ups");

        // Match event on port one, then port zero
        p1_xen <= 8'h0F;
        p1_xval <= 8'h05;
        wr_reg(ADDR_P1_MASK, 8'h0F);
        wr_reg(ADDR_P1_VALUE, 8'h05);
        wr_reg(ADDR_EXT_IE2, 8'h02);
        rd_reg(ADDR_P1_MASK, 1'b0, rd);
        `CHK(rd, 8'h0F, "compare mask readback")
        idle(3);
        `CHK({irq, wake}, 2'b00, "masked pins equal")
        p1_xval <= 8'h04;
        idle(3);
        `CHK({irq, wake}, 2'b11, "port one mismatch")
        wr_reg(ADDR_EXT_IE2, 8'h00);
        idle(3);
        `CHK({irq, wake}, 2'b01, "interrupt masked")
        p1_xval <= 8'h05;
        wr_reg(ADDR_ROUTE_CFG, 8'h00);
        wr_reg(ADDR_P0_MASK, 8'h80);
        p0_xen <= 8'h80;
        p0_xval <= 8'h80;
        idle(3);
        `CHK(wake, 1'b1, "port zero mismatch, crossbar off")
        $display("test done: match event");
        tally_and_finish();
    end
endmodule
